// ===== gtm_pkg.sv
// Package of constants and carrier types for the gated 16-bit timer
package gtm_pkg;
  localparam int GTM_COUNT_W = 16;
  localparam logic [15:0] GTM_COUNT_RESET = 16'h0000;
  localparam logic [15:0] GTM_COUNT_MAX = 16'hFFFF;
  localparam logic [7:0] GTM_PRIOR_MAX = 8'hFF;
  localparam logic [1:0] GTM_SRC_PIN = 2'h0;
  localparam logic [1:0] GTM_SRC_WRAP = 2'h1;
  localparam logic [1:0] GTM_SRC_CMP1 = 2'h2;
  localparam logic [1:0] GTM_SRC_CMP2 = 2'h3;
  localparam int GTM_SYNC_STAGES = 2;

  typedef struct packed {
    logic counter_on;
    logic gated_count_enable;
    logic gate_polarity;
    logic [1:0] gate_source_select;
    logic gate_toggle_mode;
    logic gate_single_pulse_mode;
    logic sync_bypass;
  } gtm_cfg_t;

  typedef struct packed {
    logic overflow_irq_enable;
    logic gate_event_irq_enable;
    logic peripheral_irq_enable;
    logic global_irq_enable;
  } gtm_irq_en_t;

  typedef struct packed {
    logic gate_pin;
    logic comparator_one_output;
    logic comparator_two_output;
  } gtm_gate_in_t;
endpackage : gtm_pkg

// ===== gtm_sync.sv
// Two-stage synchroniser for one level
module gtm_sync
  import gtm_pkg::*;
#(
  parameter int STAGES = GTM_SYNC_STAGES
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic async_i,
  output logic sync_o
);
  if (STAGES < 2) begin : g_bad_stages
    $error("gtm_sync needs at least two stages");
  end

  logic [STAGES-1:0] chain;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      chain <= '0;
    end else begin
      chain <= {chain[STAGES-2:0], async_i};
    end
  end

  assign sync_o = chain[STAGES-1];
endmodule // gtm_sync

// ===== gtm_prior_timer.sv
// Free-running 8-bit prior timer giving a wrap pulse
module gtm_prior_timer
  import gtm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic tick_i,
  output logic [7:0] value_o,
  output logic wrap_pulse_o
);
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      value_o <= 8'h00;
    end else if (tick_i) begin
      value_o <= value_o + 8'h01;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wrap_pulse_o <= 1'b0;
    end else begin
      wrap_pulse_o <= tick_i && (value_o == GTM_PRIOR_MAX);
    end
  end
endmodule // gtm_prior_timer

// ===== gtm_gated_timer.sv
// Gate control and 16-bit counter of the gated timer
////////////////////////////////////////////////////////////////////////////////
// Function
// - Gate open: count on clock edge
// - Gate closed: hold count
// - Polarity selects active gate level
// - Two-bit field selects gate source
// - Prior timer wrap makes gate pulse
// - Toggle mode flip-flop flips per rising edge
// - Toggle clear forces flip-flop zero
// - Arm then count from next edge
// - Arm clears on captured pulse trailing edge
// - Disarmed ignores gate events
// - Toggle plus single-pulse counts full cycle
// - Gate level readable always
// - Gate level fall sets event flag
// - Event flag and enable raise request
// - Event flag works without gating
// - Rollover sets overflow flag
// - Overflow irq needs overflow, peripheral and global enables
// - Sleep counting only asynchronous mode
// - Sleep overflow wakes processor
// - Counter off, free or gated
// - Bypass external input runs in sleep
module gtm_gated_timer
  import gtm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire gtm_cfg_t cfg_i,
  input wire gtm_irq_en_t irq_en_i,
  input wire gtm_gate_in_t gate_in_i,
  input wire logic count_tick_i,
  input wire logic external_count_input_i,
  input wire logic prior_tick_i,
  input wire logic sleep_i,
  input wire logic arm_set_i,
  input wire logic arm_clear_i,
  input wire logic count_write_i,
  input wire logic [15:0] count_wdata_i,
  input wire logic gate_event_clear_i,
  input wire logic overflow_clear_i,
  output logic [15:0] count_o,
  output logic gate_arm_flag_o,
  output logic gate_level_status_o,
  output logic gate_event_flag_o,
  output logic overflow_flag_o,
  output logic gate_irq_o,
  output logic overflow_irq_o,
  output logic wake_o
);
  logic wrap_pulse;
  logic pin_sync;
  logic cmp1_sync;
  logic cmp2_sync;
  logic ext_sync;
  logic src_sel;
  logic src_pol;
  logic src_prev;
  logic toggle_ff;
  logic toggled;
  logic spm_gate;
  logic spm_armed_seen;
  logic gate_level;
  logic level_prev;
  logic ext_prev;
  logic advance;
  logic run_ok;
  logic gate_ok;
  logic [15:0] next_count;

  ////////////////////////////////////////////////////////////////////////////
  // Sources
  gtm_prior_timer u_prior (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .tick_i(prior_tick_i),
    .value_o(),
    .wrap_pulse_o(wrap_pulse)
  );

  gtm_sync u_sync_pin (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .async_i(gate_in_i.gate_pin),
    .sync_o(pin_sync)
  );

  gtm_sync u_sync_cmp1 (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .async_i(gate_in_i.comparator_one_output),
    .sync_o(cmp1_sync)
  );

  gtm_sync u_sync_cmp2 (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .async_i(gate_in_i.comparator_two_output),
    .sync_o(cmp2_sync)
  );

  gtm_sync u_sync_ext (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .async_i(external_count_input_i),
    .sync_o(ext_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Gate path
  always_comb begin
    if (cfg_i.gate_source_select == GTM_SRC_PIN) begin
      src_sel = pin_sync;
    end else if (cfg_i.gate_source_select == GTM_SRC_WRAP) begin
      src_sel = wrap_pulse;
    end else if (cfg_i.gate_source_select == GTM_SRC_CMP1) begin
      src_sel = cmp1_sync;
    end else begin
      src_sel = cmp2_sync;
    end
  end

  assign src_pol = src_sel ^ ~cfg_i.gate_polarity;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      src_prev <= 1'b0;
    end else begin
      src_prev <= src_pol;
    end
  end

  // Toggle flip-flop, cleared when off
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      toggle_ff <= 1'b0;
    end else if (!cfg_i.gate_toggle_mode || !cfg_i.counter_on) begin
      toggle_ff <= 1'b0;
    end else if (src_pol && !src_prev) begin
      toggle_ff <= ~toggle_ff;
    end
  end

  assign toggled = cfg_i.gate_toggle_mode ? toggle_ff : src_pol;

  // Single-pulse: open from first rising edge after arm to its fall
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      spm_armed_seen <= 1'b0;
    end else if (!gate_arm_flag_o) begin
      spm_armed_seen <= 1'b0;
    end else if (toggled && !spm_gate_prev_level()) begin
      spm_armed_seen <= 1'b1;
    end
  end

  logic toggled_prev;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      toggled_prev <= 1'b0;
    end else begin
      toggled_prev <= toggled;
    end
  end

  function automatic logic spm_gate_prev_level();
    return toggled_prev;
  endfunction

  assign spm_gate = gate_arm_flag_o && toggled && (spm_armed_seen || !toggled_prev);
  assign gate_level = cfg_i.gate_single_pulse_mode ? spm_gate : toggled;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gate_arm_flag_o <= 1'b0;
    end else if (arm_set_i) begin
      gate_arm_flag_o <= 1'b1;
    end else if (arm_clear_i) begin
      gate_arm_flag_o <= 1'b0;
    end else if (cfg_i.gate_single_pulse_mode && spm_armed_seen && !toggled) begin
      gate_arm_flag_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gate_level_status_o <= 1'b0;
    end else begin
      gate_level_status_o <= gate_level;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      level_prev <= 1'b0;
    end else begin
      level_prev <= gate_level_status_o;
    end
  end

  // Gate event flag, set wins over clear
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gate_event_flag_o <= 1'b0;
    end else if (level_prev && !gate_level_status_o) begin
      gate_event_flag_o <= 1'b1;
    end else if (gate_event_clear_i) begin
      gate_event_flag_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_sync;
    end
  end

  assign run_ok = !sleep_i || cfg_i.sync_bypass;
  assign gate_ok = !cfg_i.gated_count_enable || gate_level_status_o;
  assign advance = cfg_i.counter_on && gate_ok && run_ok &&
                   (cfg_i.sync_bypass ? (ext_sync && !ext_prev) : count_tick_i);

  always_comb begin
    next_count = count_o;
    if (count_write_i) begin
      next_count = count_wdata_i;
    end else if (advance) begin
      next_count = count_o + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_o <= GTM_COUNT_RESET;
    end else begin
      count_o <= next_count;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      overflow_flag_o <= 1'b0;
    end else if (advance && !count_write_i && count_o == GTM_COUNT_MAX) begin
      overflow_flag_o <= 1'b1;
    end else if (overflow_clear_i) begin
      overflow_flag_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Requests
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gate_irq_o <= 1'b0;
      overflow_irq_o <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      gate_irq_o <= gate_event_flag_o && irq_en_i.gate_event_irq_enable;
      overflow_irq_o <= overflow_flag_o && cfg_i.counter_on && irq_en_i.overflow_irq_enable &&
                        irq_en_i.peripheral_irq_enable && irq_en_i.global_irq_enable;
      wake_o <= sleep_i && overflow_flag_o && cfg_i.counter_on &&
                irq_en_i.overflow_irq_enable && irq_en_i.peripheral_irq_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_hold;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (!cfg_i.counter_on && !count_write_i) |=> $stable(count_o);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved while off");

  property p_gated_hold;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (cfg_i.gated_count_enable && !gate_level_status_o && !count_write_i) |=> $stable(count_o);
  endproperty
  a_gated_hold: assert property (p_gated_hold) else $error("count moved gate closed");

  property p_ovf;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (advance && !count_write_i && count_o == 16'hFFFF) |=> (overflow_flag_o && count_o == 16'h0000);
  endproperty
  a_ovf: assert property (p_ovf) else $error("rollover flag missing");

  property p_gevt;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      $fell(gate_level_status_o) |=> gate_event_flag_o;
  endproperty
  a_gevt: assert property (p_gevt) else $error("gate event flag missing");

  property p_tog_clear;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      !cfg_i.gate_toggle_mode |=> !toggle_ff;
  endproperty
  a_tog_clear: assert property (p_tog_clear) else $error("toggle not cleared");

  property p_girq;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (gate_event_flag_o && irq_en_i.gate_event_irq_enable) |=> gate_irq_o;
  endproperty
  a_girq: assert property (p_girq) else $error("gate irq missing");

  property p_oirq;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      overflow_irq_o |-> $past(overflow_flag_o && irq_en_i.global_irq_enable);
  endproperty
  a_oirq: assert property (p_oirq) else $error("overflow irq unqualified");

  property p_sleep;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (sleep_i && !cfg_i.sync_bypass && !count_write_i) |=> $stable(count_o);
  endproperty
  a_sleep: assert property (p_sleep) else $error("count ran in sleep");

  property p_disarmed;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (cfg_i.gate_single_pulse_mode && !gate_arm_flag_o && !arm_set_i) ##1
        cfg_i.gate_single_pulse_mode |=> !gate_level_status_o;
  endproperty
  a_disarmed: assert property (p_disarmed) else $error("gate open while disarmed");

  c_ovf: cover property (@(posedge clk_sys_i) overflow_flag_o && overflow_irq_o);
  c_spm: cover property (@(posedge clk_sys_i) $fell(gate_arm_flag_o));
  c_tog: cover property (@(posedge clk_sys_i) $rose(toggle_ff));
  c_wake: cover property (@(posedge clk_sys_i) wake_o);
  c_girq: cover property (@(posedge clk_sys_i) gate_irq_o);
endmodule // gtm_gated_timer

// ===== gtm_gate_src.sv
// Gate source model: one timed pulse on a chosen gate line
module gtm_gate_src
  import gtm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic fire_i,
  input wire logic [1:0] sel_i,
  input wire logic [7:0] width_i,
  output gtm_gate_in_t gate_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left;
  logic [1:0] sel;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      left <= 8'h00;
      sel <= 2'h0;
    end else if (fire_i) begin
      left <= width_i;
      sel <= sel_i;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  assign gate_o.gate_pin = (left != 8'h00) && (sel == GTM_SRC_PIN);
  assign gate_o.comparator_one_output = (left != 8'h00) && (sel == GTM_SRC_CMP1);
  assign gate_o.comparator_two_output = (left != 8'h00) && (sel == GTM_SRC_CMP2);
endmodule // gtm_gate_src

// ===== gtm_gated_timer_tb.sv
// Testbench for the gated 16-bit timer
module gtm_gated_timer_tb;
  import gtm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  gtm_cfg_t cfg = '0;
  gtm_irq_en_t ien = '0;
  gtm_gate_in_t gin;
  logic ext = 1'b0, ptick = 1'b0, sleep = 1'b0, aset = 1'b0, aclr = 1'b0;
  logic cw = 1'b0, gclr = 1'b0, oclr = 1'b0, fire = 1'b0;
  logic tick = 1'b1;
  logic [1:0] fsel = 2'h0;
  logic [7:0] fw = 8'h00;
  logic [15:0] cwd = 16'h0000, cnt, c0;
  logic arm, lvl, gflag, oflag, girq, oirq, wake;
  int num_errors = 0, samples_checked = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  gtm_gated_timer uut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .cfg_i(cfg),
    .irq_en_i(ien), .gate_in_i(gin), .count_tick_i(tick), .external_count_input_i(ext),
    .prior_tick_i(ptick), .sleep_i(sleep), .arm_set_i(aset), .arm_clear_i(aclr),
    .count_write_i(cw), .count_wdata_i(cwd), .gate_event_clear_i(gclr),
    .overflow_clear_i(oclr), .count_o(cnt), .gate_arm_flag_o(arm),
    .gate_level_status_o(lvl), .gate_event_flag_o(gflag), .overflow_flag_o(oflag),
    .gate_irq_o(girq), .overflow_irq_o(oirq), .wake_o(wake));
  gtm_gate_src src (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .fire_i(fire),
    .sel_i(fsel), .width_i(fw), .gate_o(gin));
  ////////////////////////////////////////
  task automatic results();
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic chk1(input logic seen, input logic exp);
    check({15'h0000, seen}, {15'h0000, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #5;
  endtask
  task automatic wait_hi(input logic which);
    for (int i = 0; i < 40 && (which ? gflag : lvl) !== 1'b1; i++) cyc(1);
    if ((which ? gflag : lvl) !== 1'b1) begin
      num_errors++;
      results();
    end
  endtask
  task automatic pulse(input logic [1:0] s, input logic [7:0] w);
    fsel = s;
    fw = w;
    fire = 1'b1;
    cyc(1);
    fire = 1'b0;
  endtask
  task automatic load(input logic [15:0] v);
    cwd = v;
    cw = 1'b1;
    cyc(1);
    cw = 1'b0;
    cyc(1);
  endtask
  ////////////////////////////////////////
  task automatic t_enable();
    check(cnt, 16'h0000);
    cfg.counter_on = 1'b1;
    cyc(10);
    chk1(cnt != 16'h0000, 1'b1);
    tick = 1'b0;
    c0 = cnt;
    cyc(4);
    check(cnt, c0);
    tick = 1'b1;
    cfg.counter_on = 1'b0;
    cyc(2);
    c0 = cnt;
    cyc(5);
    check(cnt, c0);
  endtask
  task automatic t_gate();
    cfg.counter_on = 1'b1;
    cfg.gated_count_enable = 1'b1;
    for (int s = 0; s < 4; s++) begin
      for (int p = 0; p < 2 && s != 1; p++) begin
        cfg.gate_source_select = 2'(s);
        cfg.gate_polarity = 1'(p);
        cyc(6);
        c0 = cnt;
        cyc(6);
        chk1(cnt != c0, 1'(1 - p));
        pulse(2'(s), 8'h14);
        cyc(6);
        c0 = cnt;
        cyc(6);
        chk1(cnt != c0, 1'(p));
        cyc(14);
      end
    end
  endtask
  task automatic t_wrap();
    cfg.gate_source_select = GTM_SRC_WRAP;
    load(16'h0000);
    ptick = 1'b1;
    cyc(250);
    check(cnt, 16'h0000);
    cyc(6);
    ptick = 1'b0;
    cyc(6);
    chk1(cnt != 16'h0000, 1'b1);
  endtask
  task automatic t_event();
    cfg = '0;
    cfg.gate_polarity = 1'b1;
    ien.gate_event_irq_enable = 1'b1;
    cyc(6);
    gclr = 1'b1;
    cyc(1);
    gclr = 1'b0;
    pulse(GTM_SRC_PIN, 8'h08);
    wait_hi(1'b0);
    chk1(gflag, 1'b0);
    wait_hi(1'b1);
    chk1(lvl, 1'b0);
    cyc(2);
    chk1(girq, 1'b1);
    ien.gate_event_irq_enable = 1'b0;
    cyc(2);
    chk1(girq, 1'b0);
  endtask
  task automatic t_toggle();
    cfg.counter_on = 1'b1;
    cfg.gate_toggle_mode = 1'b1;
    cyc(4);
    for (int k = 0; k < 3; k++) begin
      pulse(GTM_SRC_PIN, 8'h04);
      cyc(12);
      chk1(lvl, 1'(k % 2 == 0));
    end
    cfg.gate_toggle_mode = 1'b0;
    cyc(4);
    chk1(lvl, 1'b0);
  endtask
  task automatic t_single(input logic tm);
    cfg.counter_on = 1'b1;
    cfg.gated_count_enable = 1'b1;
    cfg.gate_single_pulse_mode = 1'b1;
    cfg.gate_toggle_mode = tm;
    cyc(4);
    load(16'h0000);
    aset = 1'b1;
    cyc(1);
    aset = 1'b0;
    cyc(4);
    chk1(arm, 1'b1);
    check(cnt, 16'h0000);
    pulse(GTM_SRC_PIN, 8'h0A);
    cyc(20);
    if (tm) pulse(GTM_SRC_PIN, 8'h0A);
    cyc(20);
    chk1(arm, 1'b0);
    chk1(cnt > 16'h0009, 1'b1);
    c0 = cnt;
    pulse(GTM_SRC_PIN, 8'h0A);
    cyc(20);
    check(cnt, c0);
    cfg.gate_single_pulse_mode = 1'b0;
    aclr = 1'b1;
    cyc(1);
    aclr = 1'b0;
    cfg.gate_toggle_mode = 1'b0;
  endtask
  task automatic t_over();
    cfg = '0;
    load(16'hFFFF);
    ien.overflow_irq_enable = 1'b1;
    ien.peripheral_irq_enable = 1'b1;
    cfg.counter_on = 1'b1;
    cyc(1);
    cfg.counter_on = 1'b0;
    cyc(3);
    check(cnt, 16'h0000);
    chk1(oflag, 1'b1);
    chk1(oirq, 1'b0);
    ien.global_irq_enable = 1'b1;
    cyc(2);
    chk1(oirq, 1'b0);
    cfg.counter_on = 1'b1;
    cyc(2);
    chk1(oirq, 1'b1);
    oclr = 1'b1;
    cyc(1);
    oclr = 1'b0;
    cyc(1);
    chk1(oflag, 1'b0);
  endtask
  task automatic t_sleep();
    sleep = 1'b1;
    load(16'hFFFF);
    cfg.counter_on = 1'b1;
    cyc(8);
    check(cnt, 16'hFFFF);
    cfg.sync_bypass = 1'b1;
    repeat (4) begin
      ext = ~ext;
      cyc(2);
    end
    cyc(6);
    check(cnt, 16'h0001);
    chk1(wake, 1'b1);
    sleep = 1'b0;
  endtask
  initial begin
    repeat (3) @(posedge clk_sys_i);
    #5;
    reset_n_i = 1'b1;
    cyc(4);
    t_enable();
    t_gate();
    t_wrap();
    t_event();
    t_toggle();
    t_single(1'b0);
    t_single(1'b1);
    t_over();
    t_sleep();
    results();
  end
endmodule // gtm_gated_timer_tb
